// file: rtc_calendar.sv
/*
 * Calendar counters, alarm compare, event flags with read-to-clear
 * sequences, timebases and stopwatch, behind an APB slave.
 * Assumes APB signals synchronous to clock_i (20 MHz) and a host
 * that keeps each request stable until pready is seen.
 */
// Operation
// - day flag sets on day increment; status read then day read clears
// - hour flag sets on hour increment; status then hour read clears
// - minute flag sets on minute increment; status then minute read clears
// - second flag sets on second increment; status then second read clears
// - interrupt request while any flag and its enable are both set
// - timebase one flag every 0.5 or 0.125 s; cleared via stopwatch read
// - timebase two flag every 0.25 or 0.0625 s; cleared via stopwatch read
// - alarm flag sets when hour and minute equal alarm hour and minute
// - alarm registers take any value; out-of-range never matches
// - reads never disturb counting; valid writes load and count on
// - seconds wrap after 59; writes above 59 ignored
// - minutes wrap after 59; writes above 59 ignored
// - hours wrap after 23; writes above 23 ignored
// - day wraps to one after month length; invalid day writes ignored
// - month wraps to one after 12; writes outside 1..12 ignored
// - year is signed offset from 2000, valid -99 to +99
// - weekday wraps after 6; writes above 6 ignored
// - calendar writes only take effect after the unlock sequence
// - stopwatch register read-only; reset or clear bit zeroes it
// - stopwatch counts hundredths and wraps to zero after 0x63
// - timebases and stopwatch run from the uncompensated clock
// - fast select picks 0.125/0.0625 s, else 0.5/0.25 s
// - run enable gates all counting; disabling keeps contents
`timescale 1ns/1ns
module rtc_calendar #(
    parameter int SECOND_CYCLES = rtc_pkg::SECOND_CYCLES,
    parameter int SIXTEENTH_CYCLES = rtc_pkg::SIXTEENTH_CYCLES,
    parameter int HUNDREDTH_CYCLES = rtc_pkg::HUNDREDTH_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o
);
    localparam logic [rtc_pkg::DIV_W-1:0] SEC_LAST =
        rtc_pkg::DIV_W'(SECOND_CYCLES - 1);
    localparam logic [rtc_pkg::DIV_W-1:0] TB_LAST =
        rtc_pkg::DIV_W'(SIXTEENTH_CYCLES - 1);
    localparam logic [rtc_pkg::DIV_W-1:0] SW_LAST =
        rtc_pkg::DIV_W'(HUNDREDTH_CYCLES - 1);

    // thirty-day months; february is settled by the leap test
    localparam logic [7:0] APRIL = 8'h04;
    localparam logic [7:0] JUNE = 8'h06;
    localparam logic [7:0] SEPTEMBER = 8'h09;
    localparam logic [7:0] NOVEMBER = 8'h0b;
    localparam logic [1:0] LEAP_LOW_BITS = 2'h0;

    rtc_pkg::rtc_state_t s_q;
    rtc_pkg::rtc_state_t s_d;

    // month length from month and leap year (offset divisible by four)
    function automatic logic [7:0] month_days(input logic [7:0] month,
                                              input logic [7:0] year);
        logic [7:0] days;
        days = rtc_pkg::DAYS_31;
        unique case (month)
            APRIL, JUNE, SEPTEMBER, NOVEMBER: days = rtc_pkg::DAYS_30;
            rtc_pkg::FEBRUARY: begin
                // negative offsets keep the low bits, so -4 is leap too
                days = (year[1:0] == LEAP_LOW_BITS) ? rtc_pkg::DAYS_29
                                           : rtc_pkg::DAYS_28;
            end
            default: days = rtc_pkg::DAYS_31;
        endcase
        return days;
    endfunction

    logic rd_done;
    logic wr_done;
    logic open_now;
    logic sec_tick;
    logic tb_tick;
    logic sw_tick;
    logic match_now;
    logic [7:0] dim;
    logic [7:0] wbyte;
    logic [rtc_pkg::NUM_FLAGS-1:0] evt;
    logic [rtc_pkg::NUM_FLAGS-1:0] clr;
    logic [31:0] rdata;
    logic mapped;

    // next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        evt = '0;
        clr = '0;
        sec_tick = 1'b0;
        tb_tick = 1'b0;
        sw_tick = 1'b0;
        wbyte = pwdata_i[7:0];
        rd_done = psel_i & penable_i & s_q.pready & ~pwrite_i;
        wr_done = psel_i & penable_i & s_q.pready & pwrite_i;
        open_now = (s_q.unlock == rtc_pkg::RTC_OPEN);
        dim = month_days(s_q.month, s_q.year);

        // read mux; unmapped addresses read zero with pslverr
        mapped = 1'b1;
        rdata = '0;
        unique case (paddr_i)
            rtc_pkg::OFS_IRQ_ENABLE:
                rdata[rtc_pkg::NUM_FLAGS-1:0] = s_q.irq_en;
            rtc_pkg::OFS_CONTROL: begin
                // the stopwatch clear bit acts on a write only, reads zero
                rdata[rtc_pkg::CTL_RUN] = s_q.run;
                rdata[rtc_pkg::CTL_TB_FAST] = s_q.tb_fast;
                rdata[rtc_pkg::CTL_SW_EN] = s_q.sw_en;
            end
            rtc_pkg::OFS_UNLOCK: rdata[rtc_pkg::UNLOCK_STATUS_BIT] = open_now;
            rtc_pkg::OFS_FLAGS:
                rdata[rtc_pkg::NUM_FLAGS-1:0] = s_q.flags;
            rtc_pkg::OFS_ALARM_MINUTE: rdata[7:0] = s_q.alm_min;
            rtc_pkg::OFS_ALARM_HOUR: rdata[7:0] = s_q.alm_hour;
            rtc_pkg::OFS_SECOND: rdata[7:0] = s_q.sec;
            rtc_pkg::OFS_MINUTE: rdata[7:0] = s_q.min;
            rtc_pkg::OFS_HOUR: rdata[7:0] = s_q.hour;
            rtc_pkg::OFS_DAY: rdata[7:0] = s_q.day;
            rtc_pkg::OFS_MONTH: rdata[7:0] = s_q.month;
            rtc_pkg::OFS_WEEKDAY: rdata[7:0] = s_q.wday;
            rtc_pkg::OFS_STOPWATCH: rdata[7:0] = s_q.stopwatch;
            rtc_pkg::OFS_YEAR: rdata[7:0] = s_q.year;
            default: mapped = 1'b0;
        endcase

        // one wait state: data captured in the first access cycle
        // fixed latency keeps the address decode off the pready path
        if (psel_i && penable_i && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.pslverr = ~mapped;
            s_d.prdata = rdata;
        end else begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
        end

        // prescalers, all frozen while the module is stopped
        // the second tick is uncompensated; trimming lives elsewhere
        if (s_q.run) begin
            if (s_q.sec_div == SEC_LAST) begin
                s_d.sec_div = '0;
                sec_tick = 1'b1;
            end else begin
                s_d.sec_div = s_q.sec_div + 1'b1;
            end
            // timebases and stopwatch share no divider with seconds
            if (s_q.tb_div == TB_LAST) begin
                s_d.tb_div = '0;
                tb_tick = 1'b1;
                s_d.tb_phase = s_q.tb_phase + 1'b1;
            end else begin
                s_d.tb_div = s_q.tb_div + 1'b1;
            end
            if (s_q.sw_en) begin
                if (s_q.sw_div == SW_LAST) begin
                    s_d.sw_div = '0;
                    sw_tick = 1'b1;
                end else begin
                    s_d.sw_div = s_q.sw_div + 1'b1;
                end
            end
        end

        // timebase ticks from the sixteenth-second phase
        // one phase counter serves both rates, so the flags stay aligned
        if (tb_tick) begin
            if (s_q.tb_fast) begin
                evt[rtc_pkg::FLG_TB2] = 1'b1;
                evt[rtc_pkg::FLG_TB1] = s_q.tb_phase[0];
            end else begin
                evt[rtc_pkg::FLG_TB2] =
                    (s_q.tb_phase[1:0] == rtc_pkg::TB2_SLOW_PHASE);
                evt[rtc_pkg::FLG_TB1] =
                    (s_q.tb_phase == rtc_pkg::TB_PHASE_LAST);
            end
        end

        // stopwatch hundredths
        if (sw_tick) begin
            s_d.stopwatch = (s_q.stopwatch == rtc_pkg::STOPWATCH_MAX) ?
                8'h00 : s_q.stopwatch + 8'h01;
        end

        // calendar ripple: every carry lands on the same second tick
        if (sec_tick) begin
            evt[rtc_pkg::FLG_SEC] = 1'b1;
            if (s_q.sec == rtc_pkg::SEC_MAX) begin
                s_d.sec = 8'h00;
                evt[rtc_pkg::FLG_MIN] = 1'b1;
                if (s_q.min == rtc_pkg::MIN_MAX) begin
                    s_d.min = 8'h00;
                    evt[rtc_pkg::FLG_HOUR] = 1'b1;
                    if (s_q.hour == rtc_pkg::HOUR_MAX) begin
                        s_d.hour = 8'h00;
                        evt[rtc_pkg::FLG_DAY] = 1'b1;
                        // weekday follows the day, blind to month length
                        s_d.wday = (s_q.wday >= rtc_pkg::WDAY_MAX) ?
                            8'h00 : s_q.wday + 8'h01;
                        if (s_q.day >= dim) begin
                            s_d.day = rtc_pkg::FIRST_DAY;
                            if (s_q.month >= rtc_pkg::MONTH_MAX) begin
                                s_d.month = rtc_pkg::FIRST_MONTH;
                                // year wraps within its valid range
                                s_d.year = ($signed(s_q.year) >=
                                    rtc_pkg::YEAR_MAX) ?
                                    rtc_pkg::YEAR_MIN : s_q.year + 8'h01;
                            end else begin
                                s_d.month = s_q.month + 8'h01;
                            end
                        end else begin
                            s_d.day = s_q.day + 8'h01;
                        end
                    end else begin
                        s_d.hour = s_q.hour + 8'h01;
                    end
                end else begin
                    s_d.min = s_q.min + 8'h01;
                end
            end else begin
                s_d.sec = s_q.sec + 8'h01;
            end
        end

        // register writes; a valid write wins over a same-cycle tick
        // protected or out-of-range writes still end the transfer
        if (wr_done) begin
            unique case (paddr_i)
                rtc_pkg::OFS_IRQ_ENABLE:
                    s_d.irq_en = pwdata_i[rtc_pkg::NUM_FLAGS-1:0];
                rtc_pkg::OFS_CONTROL: begin
                    if (open_now) begin
                        s_d.run = pwdata_i[rtc_pkg::CTL_RUN];
                    end
                    s_d.tb_fast = pwdata_i[rtc_pkg::CTL_TB_FAST];
                    s_d.sw_en = pwdata_i[rtc_pkg::CTL_SW_EN];
                    // zeroing the divider makes the first hundredth whole
                    if (pwdata_i[rtc_pkg::CTL_SW_CLEAR]) begin
                        s_d.stopwatch = 8'h00;
                        s_d.sw_div = '0;
                    end
                end
                rtc_pkg::OFS_UNLOCK: begin
                    // any break in the sequence re-protects; 00 restarts
                    // run bit and calendar writes wait for the open state
                    s_d.unlock = rtc_pkg::RTC_LOCKED;
                    if (wbyte[1:0] == rtc_pkg::UNLOCK_STEP0) begin
                        s_d.unlock = rtc_pkg::RTC_SEQ1;
                    end else if (s_q.unlock == rtc_pkg::RTC_SEQ1 &&
                                 wbyte[1:0] == rtc_pkg::UNLOCK_STEP1) begin
                        s_d.unlock = rtc_pkg::RTC_SEQ2;
                    end else if (s_q.unlock == rtc_pkg::RTC_SEQ2 &&
                                 wbyte[1:0] == rtc_pkg::UNLOCK_STEP2) begin
                        s_d.unlock = rtc_pkg::RTC_SEQ3;
                    end else if (s_q.unlock == rtc_pkg::RTC_SEQ3 &&
                                 wbyte[1:0] == rtc_pkg::UNLOCK_STEP3) begin
                        s_d.unlock = rtc_pkg::RTC_OPEN;
                    end
                end
                rtc_pkg::OFS_ALARM_MINUTE: s_d.alm_min = wbyte;
                rtc_pkg::OFS_ALARM_HOUR: s_d.alm_hour = wbyte;
                rtc_pkg::OFS_SECOND: begin
                    if (open_now && wbyte <= rtc_pkg::SEC_MAX) begin
                        s_d.sec = wbyte;
                    end
                end
                rtc_pkg::OFS_MINUTE: begin
                    if (open_now && wbyte <= rtc_pkg::MIN_MAX) begin
                        s_d.min = wbyte;
                    end
                end
                rtc_pkg::OFS_HOUR: begin
                    if (open_now && wbyte <= rtc_pkg::HOUR_MAX) begin
                        s_d.hour = wbyte;
                    end
                end
                rtc_pkg::OFS_DAY: begin
                    if (open_now && wbyte >= rtc_pkg::FIRST_DAY &&
                        wbyte <= dim) begin
                        s_d.day = wbyte;
                    end
                end
                rtc_pkg::OFS_MONTH: begin
                    if (open_now && wbyte >= rtc_pkg::FIRST_MONTH &&
                        wbyte <= rtc_pkg::MONTH_MAX) begin
                        s_d.month = wbyte;
                    end
                end
                rtc_pkg::OFS_YEAR: begin
                    if (open_now && $signed(wbyte) >= rtc_pkg::YEAR_MIN &&
                        $signed(wbyte) <= rtc_pkg::YEAR_MAX) begin
                        s_d.year = wbyte;
                    end
                end
                rtc_pkg::OFS_WEEKDAY: begin
                    if (open_now && wbyte <= rtc_pkg::WDAY_MAX) begin
                        s_d.wday = wbyte;
                    end
                end
                default: s_d.unlock = s_q.unlock;
            endcase
        end

        // alarm compare on the loaded/updated counters, edge only
        // edge only, so a standing match never refills a cleared flag
        match_now = (s_d.hour == s_q.alm_hour) &&
                    (s_d.min == s_q.alm_min) &&
                    (s_q.alm_min <= rtc_pkg::MIN_MAX) &&
                    (s_q.alm_hour <= rtc_pkg::HOUR_MAX);
        s_d.match = match_now;
        evt[rtc_pkg::FLG_ALM] = match_now & ~s_q.match;

        // second read of the clear sequence, only recorded flags
        if (rd_done) begin
            unique case (paddr_i)
                rtc_pkg::OFS_DAY: clr[rtc_pkg::FLG_DAY] = 1'b1;
                rtc_pkg::OFS_HOUR: clr[rtc_pkg::FLG_HOUR] = 1'b1;
                rtc_pkg::OFS_MINUTE: clr[rtc_pkg::FLG_MIN] = 1'b1;
                rtc_pkg::OFS_SECOND: clr[rtc_pkg::FLG_SEC] = 1'b1;
                rtc_pkg::OFS_ALARM_HOUR: clr[rtc_pkg::FLG_ALM] = 1'b1;
                rtc_pkg::OFS_STOPWATCH: begin
                    clr[rtc_pkg::FLG_TB1] = 1'b1;
                    clr[rtc_pkg::FLG_TB2] = 1'b1;
                end
                default: clr = '0;
            endcase
        end
        // without the record, a flag set after the status read would be
        // lost to a data read that software never meant as a clear
        clr = clr & s_q.armed;
        s_d.armed = s_q.armed & ~clr;
        if (rd_done && paddr_i == rtc_pkg::OFS_FLAGS) begin
            s_d.armed = s_q.armed | s_q.flags;
        end
        // a new event in the clearing cycle survives
        s_d.flags = (s_q.flags & ~clr) | evt;

        // registered request line
        s_d.irq = |(s_d.flags & s_d.irq_en);
    end

    // single state register; calendar starts at a valid date
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.day <= rtc_pkg::FIRST_DAY;
            s_q.month <= rtc_pkg::FIRST_MONTH;
            s_q.unlock <= rtc_pkg::RTC_LOCKED;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign irq_o = s_q.irq;
endmodule

// file: rtc_calendar_properties.sv
/*
 * Port-level checks for the calendar block: bus timing, error reply,
 * read data shape and interrupt release.
 * Assumes binding to rtc_calendar; sees its ports only.
 */
`timescale 1ns/1ns
module rtc_calendar_properties #(
    parameter int SECOND_CYCLES = 20,
    parameter int SIXTEENTH_CYCLES = 8,
    parameter int HUNDREDTH_CYCLES = 4
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic irq_o
);
    logic mapped;

    // decoded register window, word aligned only
    assign mapped = paddr_i[1:0] == 2'h0 && (paddr_i <= 12'h014 ||
        (paddr_i >= 12'h030 && paddr_i <= 12'h04c));

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held more than one cycle");
    ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
        else $error("ready without access phase");
    wait_state_a: assert property (psel_i && !penable_i |-> ##2 pready_o)
        else $error("ready not in second access cycle");
    err_map_a: assert property (pready_o |-> pslverr_o == !mapped)
        else $error("error reply does not match decode");
    err_alone_a: assert property (pslverr_o |-> pready_o)
        else $error("error reply outside ready");
    upper_zero_a: assert property (pready_o && !pwrite_i |->
        prdata_o[31:8] == 24'h0) else $error("upper read bits set");
    unmapped_zero_a: assert property (pready_o && !mapped |->
        prdata_o == 32'h0) else $error("unmapped read not zero");
    sw_range_a: assert property (pready_o && paddr_i == 12'h048 |->
        prdata_o[7:0] <= 8'h63) else $error("stopwatch past wrap");
    irq_release_a: assert property ($fell(irq_o) |->
        $past(pready_o) || $past(pready_o, 2))
        else $error("interrupt dropped without bus access");

    // main scenarios reached
    wr_done_c: cover property (pready_o && pwrite_i);
    flags_rd_c: cover property (pready_o && paddr_i == 12'h00c);
    irq_c: cover property ($rose(irq_o));
endmodule

// file: rtc_pkg.sv
/*
 * Shared constants and types for the calendar and status block:
 * register byte offsets, field positions, calendar limits, timing
 * figures and the packed state record.
 * Assumes a 20 MHz system clock and a 32-bit APB register bus.
 */
package rtc_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h000;
    localparam logic [11:0] OFS_CONTROL = 12'h004;
    localparam logic [11:0] OFS_UNLOCK = 12'h008;
    localparam logic [11:0] OFS_FLAGS = 12'h00c;
    localparam logic [11:0] OFS_ALARM_MINUTE = 12'h010;
    localparam logic [11:0] OFS_ALARM_HOUR = 12'h014;
    localparam logic [11:0] OFS_SECOND = 12'h030;
    localparam logic [11:0] OFS_MINUTE = 12'h034;
    localparam logic [11:0] OFS_HOUR = 12'h038;
    localparam logic [11:0] OFS_DAY = 12'h03c;
    localparam logic [11:0] OFS_MONTH = 12'h040;
    localparam logic [11:0] OFS_WEEKDAY = 12'h044;
    localparam logic [11:0] OFS_STOPWATCH = 12'h048;
    localparam logic [11:0] OFS_YEAR = 12'h04c;

    // flag and irq enable bit positions
    localparam int FLG_TB2 = 0;
    localparam int FLG_TB1 = 1;
    localparam int FLG_SEC = 2;
    localparam int FLG_MIN = 3;
    localparam int FLG_HOUR = 4;
    localparam int FLG_DAY = 5;
    localparam int FLG_ALM = 6;
    localparam int NUM_FLAGS = 7;

    // control register fields and unlock register status bit
    localparam int CTL_RUN = 0;
    localparam int CTL_TB_FAST = 1;
    localparam int CTL_SW_EN = 2;
    localparam int CTL_SW_CLEAR = 3;
    localparam int UNLOCK_STATUS_BIT = 7;

    // write unlock sequence values
    localparam logic [1:0] UNLOCK_STEP0 = 2'h0;
    localparam logic [1:0] UNLOCK_STEP1 = 2'h1;
    localparam logic [1:0] UNLOCK_STEP2 = 2'h3;
    localparam logic [1:0] UNLOCK_STEP3 = 2'h2;

    // calendar limits
    localparam logic [7:0] SEC_MAX = 8'h3b;
    localparam logic [7:0] MIN_MAX = 8'h3b;
    localparam logic [7:0] HOUR_MAX = 8'h17;
    localparam logic [7:0] MONTH_MAX = 8'h0c;
    localparam logic [7:0] WDAY_MAX = 8'h06;
    localparam logic [7:0] FIRST_DAY = 8'h01;
    localparam logic [7:0] FIRST_MONTH = 8'h01;
    localparam logic [7:0] FEBRUARY = 8'h02;
    localparam logic [7:0] DAYS_28 = 8'h1c;
    localparam logic [7:0] DAYS_29 = 8'h1d;
    localparam logic [7:0] DAYS_30 = 8'h1e;
    localparam logic [7:0] DAYS_31 = 8'h1f;
    localparam logic signed [7:0] YEAR_MAX = 8'sh63;
    localparam logic signed [7:0] YEAR_MIN = -8'sh63;
    localparam logic [7:0] STOPWATCH_MAX = 8'h63;

    // timing: figures in microseconds, counts derived from the clock
    localparam int CLK_MHZ = 20;
    localparam int SECOND_US = 1000000;
    localparam int SIXTEENTH_US = 62500;
    localparam int HUNDREDTH_US = 10000;
    localparam int SECOND_CYCLES = SECOND_US * CLK_MHZ;
    localparam int SIXTEENTH_CYCLES = SIXTEENTH_US * CLK_MHZ;
    localparam int HUNDREDTH_CYCLES = HUNDREDTH_US * CLK_MHZ;
    localparam int DIV_W = 25;
    localparam logic [2:0] TB_PHASE_LAST = 3'h7;
    localparam logic [1:0] TB2_SLOW_PHASE = 2'h3;

    typedef enum logic [4:0] {
        RTC_LOCKED = 5'h01,
        RTC_SEQ1 = 5'h02,
        RTC_SEQ2 = 5'h04,
        RTC_SEQ3 = 5'h08,
        RTC_OPEN = 5'h10
    } rtc_unlock_t;

    typedef struct packed {
        logic [DIV_W-1:0] sec_div;
        logic [DIV_W-1:0] tb_div;
        logic [DIV_W-1:0] sw_div;
        logic [2:0] tb_phase;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] day;
        logic [7:0] month;
        logic [7:0] year;
        logic [7:0] wday;
        logic [7:0] alm_min;
        logic [7:0] alm_hour;
        logic [7:0] stopwatch;
        logic [NUM_FLAGS-1:0] irq_en;
        logic [NUM_FLAGS-1:0] flags;
        logic [NUM_FLAGS-1:0] armed;
        logic run;
        logic tb_fast;
        logic sw_en;
        logic match;
        rtc_unlock_t unlock;
        logic pready;
        logic pslverr;
        logic irq;
        logic [31:0] prdata;
    } rtc_state_t;
endpackage

// file: tb_rtc_calendar_status_counters.sv
/*
 * Self-checking bench for the calendar block: APB reads and writes
 * with expected values from the calendar rules.
 * Assumes shortened second, sixteenth and hundredth counts.
 */
`timescale 1ns/1ns
module tb_rtc_calendar_status_counters;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic irq_o;
    logic [31:0] rdv;
    logic rerr;
    int num_errors = 0;
    int checked = 0;

    rtc_calendar #(.SECOND_CYCLES(20), .SIXTEENTH_CYCLES(8),
        .HUNDREDTH_CYCLES(4)) dut (.clock_i(clock_i), .rst_i(rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o));

    // 20 MHz clock
    always #25 clock_i = ~clock_i;

    task automatic end_of_test;
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask

    // one transfer; idle edge first so no signal is set twice at once
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        int n;
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= 32'(d);
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rdv = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            end_of_test();
        end
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 0);
    endtask

    initial begin
        logic [11:0] ta[6] = '{12'h030, 12'h034, 12'h038, 12'h044,
            12'h040, 12'h040};
        int tg[6] = '{59, 59, 23, 6, 12, 2};
        int tb[6] = '{60, 60, 24, 7, 13, 0};
        logic [11:0] ra[7] = '{12'h030, 12'h034, 12'h038, 12'h03c,
            12'h040, 12'h044, 12'h04c};
        int re[7] = '{0, 0, 0, 1, 3, 0, 1};
        int ul[4] = '{0, 1, 3, 2};
        int n;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(12'h03c);
        chk("day", rdv, 1);
        rd(12'h040);
        chk("month", rdv, 1);
        rd(12'h00c);
        chk("flags", rdv[5:0], 0);
        rd(12'h048);
        chk("sw", rdv, 0);
        // locked write must not land
        apb(1'b1, 12'h030, 5);
        rd(12'h030);
        chk("locked", rdv, 0);
        for (int i = 0; i < 4; i++) apb(1'b1, 12'h008, ul[i]);
        rd(12'h008);
        chk("open", rdv[7], 1);
        // good write then bad write, good value must stay
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ta[i], tg[i]);
            apb(1'b1, ta[i], tb[i]);
            rd(ta[i]);
            chk("range", rdv, tg[i]);
        end
        apb(1'b1, 12'h04c, 1);
        rd(12'h04c);
        chk("year", rdv, 1);
        // a day valid in a common-year february, then one past its end
        apb(1'b1, 12'h03c, 28);
        apb(1'b1, 12'h03c, 29);
        rd(12'h03c);
        chk("feb", rdv, 28);
        apb(1'b1, 12'h014, 24);
        rd(12'h014);
        chk("alm_any", rdv, 24);
        rd(12'h00c);
        rd(12'h014);
        apb(1'b1, 12'h014, 0);
        rd(12'h00c);
        chk("alm_clr", rdv[6], 0);
        // run across the carry chain from second up to month, stop soon after
        apb(1'b1, 12'h004, 1);
        n = 0;
        do begin
            rd(12'h00c);
            n++;
        end while (rdv[2] !== 1'b1 && n < 40);
        if (n >= 40) begin
            num_errors++;
            end_of_test();
        end
        // compared before the stop write, which reloads rdv
        chk("carry", rdv[6:2], 5'h1f);
        apb(1'b1, 12'h004, 0);
        repeat (60) @(posedge clock_i);
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            chk("wrap", rdv, re[i]);
        end
        rd(12'h00c);
        chk("cleared", rdv[6:2], 5'h10);
        apb(1'b1, 12'h000, 64);
        repeat (2) @(posedge clock_i);
        chk("irq_on", irq_o, 1);
        rd(12'h00c);
        rd(12'h014);
        repeat (2) @(posedge clock_i);
        chk("irq_off", irq_o, 0);
        // fast timebase ticks, cleared through the stopwatch read
        rd(12'h00c);
        rd(12'h048);
        apb(1'b1, 12'h004, 3);
        repeat (40) @(posedge clock_i);
        apb(1'b1, 12'h004, 0);
        rd(12'h00c);
        chk("tb", rdv[1:0], 3);
        rd(12'h048);
        rd(12'h00c);
        chk("tb_clr", rdv[1:0], 0);
        // stopwatch runs past its wrap, then is stopped
        apb(1'b1, 12'h004, 5);
        repeat (420) @(posedge clock_i);
        apb(1'b1, 12'h004, 0);
        rd(12'h048);
        chk("sw_wrap", 32'(rdv < 10 && rdv != 0), 1);
        // slow rates over many sixteenths still raise both flags
        rd(12'h00c);
        chk("tb_slow", rdv[1:0], 3);
        // clear first, so a landed write to the read-only count shows
        apb(1'b1, 12'h004, 8);
        apb(1'b1, 12'h048, 5);
        rd(12'h048);
        chk("sw_clr", rdv, 0);
        rd(12'h020);
        chk("unmapped", {rerr, rdv[30:0]}, 32'h80000000);
        end_of_test();
    end
endmodule

bind rtc_calendar rtc_calendar_properties #(
    .SECOND_CYCLES(SECOND_CYCLES), .SIXTEENTH_CYCLES(SIXTEENTH_CYCLES),
    .HUNDREDTH_CYCLES(HUNDREDTH_CYCLES)) props (.clock_i(clock_i),
    .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .irq_o(irq_o));
